/* verilog/fsb_map.svh */
// fsb_map.svh: offsets, reset values and timing counts of the bound registers
// assumes: included by bare name from the design and bench files
`ifndef FSB_MAP_SVH
`define FSB_MAP_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FSB_OFS_LONG_HI 8'h1A
`define FSB_OFS_MIN_LO 8'h1B
`define FSB_OFS_MIN_HI 8'h1C
`define FSB_OFS_SHUT_LO 8'h1D
`define FSB_OFS_SHUT_HI 8'h1E
`define FSB_OFS_FW_REV 8'h1F
// ----------------------------------------------------------------
// reset values before and after firmware download
// ----------------------------------------------------------------
`define FSB_RST_MIN_LO_PRE 8'hAC
`define FSB_RST_MIN_LO_POST 8'h7E
`define FSB_RST_MIN_HI_PRE 8'h0D
`define FSB_RST_MIN_HI_POST 8'h0E
`define FSB_RST_SHUT_LO_PRE 8'h8C
`define FSB_RST_SHUT_LO_POST 8'h00
`define FSB_RST_SHUT_HI 8'h20
`define FSB_RST_FW_REV 8'h00
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define FSB_BUSY_FRAMES 2'h2
`endif

/* verilog/fsb_pkg.sv */
// fsb_pkg.sv: types shared by the bound register bank
// assumes: fsb_map.svh holds all numbers
package fsb_pkg;
    // one register access from the serial port decoder
    typedef struct packed {
        logic wr;        // write strobe, one cycle
        logic rd;        // read strobe, one cycle
        logic [7:0] addr; // register address
        logic [7:0] wdata; // write data
    } fsb_req_s;
    // applying state of staged bounds
    typedef enum logic [0:0] {FSB_IDLE, FSB_SETTLE} fsb_state_e;
endpackage

/* verilog/fsb_frame_timer.sv */
// fsb_frame_timer.sv: frame period counter, one tick per frame
// assumes: period in clock cycles from the same clock domain
`timescale 1ns/1ps
module fsb_frame_timer (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [15:0] period_in,
    output logic tick_out
);
    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    logic [15:0] cnt_reg; // cycles into the frame
    logic [15:0] cnt_next;
    logic tick_next;

    // count to period - 1, then wrap and tick
    always_comb begin
        cnt_next = cnt_reg + 16'h0001;
        tick_next = 1'b0;
        if (cnt_reg + 16'h0001 >= period_in) begin
            cnt_next = 16'h0000;
            tick_next = 1'b1;
        end
    end

    // register stage
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_out <= tick_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // no tick in the cycle after a tick while the period is two or more and stable
    AST_TICK_GAP: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (tick_out && period_in >= 16'h0002 && $stable(period_in)) |=> !tick_out)
        else $error("frame ticks closer than the period");
endmodule

/* verilog/fsb_bound_regs.sv */
// fsb_bound_regs.sv: staged frame and shutter bound registers
// assumes: register strobes come decoded from the serial port on mclk_in
//
// Functional notes
// - shortest frame bound is 16-bit cycle count
// - frame rate is clock over period
// - reads return last written, even unapplied; longest-bound bytes read zero here
// - staged values apply on longest-bound upper byte write
// - busy shows while staged bounds apply
// - automatic mode caps shutter at bound
// - shutter bound narrows frame period choice
// - agc off: shutter bound is fixed shutter
// - shortest low resets 0xAC, 0x7E after download
// - shutter low 0x8C, 0x00 after; high 0x20
// - revision shows firmware revision, else zero
`timescale 1ns/1ps
`include "fsb_map.svh"
module fsb_bound_regs
    import fsb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire fsb_req_s reg_req_in,
    input wire logic fw_running_in,
    input wire logic [7:0] fw_rev_in,
    input wire logic agc_enable_in,
    input wire logic [15:0] shutter_req_in,
    input wire logic [15:0] period_req_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic busy_out,
    output logic frame_tick_out,
    output logic [15:0] frame_period_out,
    output logic [15:0] shutter_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] min_stage_reg, min_stage_next; // readable shortest bound
    logic [15:0] shut_stage_reg, shut_stage_next; // readable shutter bound
    logic [15:0] min_app_reg, min_app_next; // shortest bound in use
    logic [15:0] shut_app_reg, shut_app_next; // shutter bound in use
    fsb_state_e state_reg, state_next; // applying state
    logic [1:0] frames_reg, frames_next; // frames seen while settling
    logic fw_seen_reg, fw_seen_next; // firmware running last cycle
    logic [7:0] rdata_next;
    logic rvalid_next;
    logic busy_next;
    logic [15:0] period_next;
    logic [15:0] shutter_next;
    logic tick; // frame end from the timer
    logic wr_min_lo, wr_min_hi, wr_shut_lo, wr_shut_hi, wr_long_hi;

    // address decode of write strobes
    assign wr_min_lo = reg_req_in.wr && reg_req_in.addr == `FSB_OFS_MIN_LO;
    assign wr_min_hi = reg_req_in.wr && reg_req_in.addr == `FSB_OFS_MIN_HI;
    assign wr_shut_lo = reg_req_in.wr && reg_req_in.addr == `FSB_OFS_SHUT_LO;
    assign wr_shut_hi = reg_req_in.wr && reg_req_in.addr == `FSB_OFS_SHUT_HI;
    assign wr_long_hi = reg_req_in.wr && reg_req_in.addr == `FSB_OFS_LONG_HI;

    // ----------------------------------------------------------------
    // frame timer
    // ----------------------------------------------------------------
    fsb_frame_timer u_timer (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .period_in(frame_period_out),
        .tick_out(tick)
    );
    assign frame_tick_out = tick;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        min_stage_next = min_stage_reg;
        shut_stage_next = shut_stage_reg;
        min_app_next = min_app_reg;
        shut_app_next = shut_app_reg;
        state_next = state_reg;
        frames_next = frames_reg;
        fw_seen_next = fw_running_in;
        rdata_next = 8'h00;
        rvalid_next = reg_req_in.rd;
        // byte writes land in staging only
        if (wr_min_lo) begin
            min_stage_next[7:0] = reg_req_in.wdata;
        end
        if (wr_min_hi) begin
            min_stage_next[15:8] = reg_req_in.wdata;
        end
        if (wr_shut_lo) begin
            shut_stage_next[7:0] = reg_req_in.wdata;
        end
        if (wr_shut_hi) begin
            shut_stage_next[15:8] = reg_req_in.wdata;
        end
        // settling wait of two frames
        case (state_reg)
            FSB_IDLE: begin
                frames_next = 2'h0;
            end
            FSB_SETTLE: begin
                if (tick) begin
                    frames_next = frames_reg + 2'h1;
                end
                if (tick && frames_reg + 2'h1 >= `FSB_BUSY_FRAMES) begin
                    state_next = FSB_IDLE;
                end
            end
            default: begin
                state_next = FSB_IDLE;
            end
        endcase
        // longest bound upper write releases staged values
        if (wr_long_hi) begin
            min_app_next = min_stage_reg;
            shut_app_next = shut_stage_reg;
            state_next = FSB_SETTLE;
            frames_next = 2'h0;
        end
        // firmware start swaps in its defaults
        if (fw_running_in && !fw_seen_reg) begin
            min_stage_next = {`FSB_RST_MIN_HI_POST, `FSB_RST_MIN_LO_POST};
            shut_stage_next = {`FSB_RST_SHUT_HI, `FSB_RST_SHUT_LO_POST};
            min_app_next = min_stage_next;
            shut_app_next = shut_stage_next;
        end
        // read mux, unmapped reads zero
        case (reg_req_in.addr)
            `FSB_OFS_MIN_LO: rdata_next = min_stage_reg[7:0];
            `FSB_OFS_MIN_HI: rdata_next = min_stage_reg[15:8];
            `FSB_OFS_SHUT_LO: rdata_next = shut_stage_reg[7:0];
            `FSB_OFS_SHUT_HI: rdata_next = shut_stage_reg[15:8];
            `FSB_OFS_FW_REV: rdata_next = fw_running_in ? fw_rev_in : `FSB_RST_FW_REV;
            default: rdata_next = 8'h00;
        endcase
        if (!reg_req_in.rd) begin
            rdata_next = 8'h00;
        end
        busy_next = state_next == FSB_SETTLE;
    end

    // ----------------------------------------------------------------
    // exposure and frame period choice
    // ----------------------------------------------------------------
    always_comb begin
        // auto caps request, manual uses bound as is
        if (agc_enable_in && shutter_req_in < shut_app_reg) begin
            shutter_next = shutter_req_in;
        end else begin
            shutter_next = shut_app_reg;
        end
        // period never below shortest bound or shutter cap
        period_next = period_req_in;
        if (period_next < min_app_reg) begin
            period_next = min_app_reg;
        end
        if (period_next < shut_app_reg) begin
            period_next = shut_app_reg;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            min_stage_reg <= {`FSB_RST_MIN_HI_PRE, `FSB_RST_MIN_LO_PRE};
            shut_stage_reg <= {`FSB_RST_SHUT_HI, `FSB_RST_SHUT_LO_PRE};
            min_app_reg <= {`FSB_RST_MIN_HI_PRE, `FSB_RST_MIN_LO_PRE};
            shut_app_reg <= {`FSB_RST_SHUT_HI, `FSB_RST_SHUT_LO_PRE};
            state_reg <= FSB_IDLE;
            frames_reg <= 2'h0;
            fw_seen_reg <= 1'b0;
            rdata_out <= 8'h00;
            rvalid_out <= 1'b0;
            busy_out <= 1'b0;
            frame_period_out <= {`FSB_RST_MIN_HI_PRE, `FSB_RST_MIN_LO_PRE};
            shutter_out <= 16'h0000;
        end else begin
            min_stage_reg <= min_stage_next;
            shut_stage_reg <= shut_stage_next;
            min_app_reg <= min_app_next;
            shut_app_reg <= shut_app_next;
            state_reg <= state_next;
            frames_reg <= frames_next;
            fw_seen_reg <= fw_seen_next;
            rdata_out <= rdata_next;
            rvalid_out <= rvalid_next;
            busy_out <= busy_next;
            frame_period_out <= period_next;
            shutter_out <= shutter_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    // a plain write of the shortest low byte, no release with it
    sequence seq_stage_wr;
        wr_min_lo && !wr_long_hi && !(fw_running_in && !fw_seen_reg);
    endsequence
    // release write of the longest upper byte
    sequence seq_release;
        wr_long_hi && !(fw_running_in && !fw_seen_reg);
    endsequence

    // write, one quiet cycle, then read of the same byte
    AST_READBACK: assert property (
        seq_stage_wr ##1 (!reg_req_in.wr && !(fw_running_in && !fw_seen_reg))
        ##1 (reg_req_in.rd && reg_req_in.addr == `FSB_OFS_MIN_LO
        && !reg_req_in.wr) |=> rdata_out == $past(reg_req_in.wdata, 3))
        else $error("shortest low byte does not read back");
    AST_STAGE_HOLD: assert property (
        seq_stage_wr |=> min_app_reg == $past(min_app_reg))
        else $error("staged write took effect early");
    AST_APPLY: assert property (
        seq_release |=> min_app_reg == $past(min_stage_reg)
        && shut_app_reg == $past(shut_stage_reg) && busy_out)
        else $error("release did not apply staged bounds");
    AST_BUSY_END: assert property (
        $fell(busy_out) |-> $past(tick) && $past(frames_reg) == 2'h1)
        else $error("busy ended before two frames");
    AST_SHUT_AUTO: assert property (
        agc_enable_in |=> shutter_out <= $past(shut_app_reg))
        else $error("auto shutter above its bound");
    AST_SHUT_MAN: assert property (
        !agc_enable_in |=> shutter_out == $past(shut_app_reg))
        else $error("manual shutter differs from bound");
    AST_PERIOD: assert property (
        1'b1 |=> frame_period_out >= $past(min_app_reg)
        && frame_period_out >= $past(shut_app_reg))
        else $error("frame period below a bound");
    AST_FW_REV: assert property (
        (reg_req_in.rd && reg_req_in.addr == `FSB_OFS_FW_REV && !fw_running_in)
        |=> rdata_out == `FSB_RST_FW_REV)
        else $error("revision not zero without firmware");
    AST_FW_DEFAULTS: assert property (
        (fw_running_in && !fw_seen_reg)
        |=> min_stage_reg == {`FSB_RST_MIN_HI_POST, `FSB_RST_MIN_LO_POST}
        && shut_stage_reg[7:0] == `FSB_RST_SHUT_LO_POST)
        else $error("firmware defaults not loaded");
endmodule

/* dv/fsb_ctrl_model.sv */
// fsb_ctrl_model.sv: controller model issuing register strobes to the bound bank
// assumes: strobes change at the falling edge of mclk_in, one cycle wide
`timescale 1ns/1ps
module fsb_ctrl_model
    import fsb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic busy_in,
    output fsb_req_s req_out
);
    // ----------------------------------------------------------------
    // register cycles
    // ----------------------------------------------------------------
    // idle port from time zero
    initial begin
        req_out = '0;
    end
    // single write; waits up to 100000 cycles for staged bounds to settle first
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (busy_in !== 1'b0 && n < 100000) begin
            @(negedge mclk_in);
            n++;
        end
        @(negedge mclk_in);
        req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk_in);
        req_out = '0;
    endtask
    // single read; answer {valid, data} stands only in the cycle after the strobe
    task automatic rd8(input logic [7:0] a, output logic [8:0] q);
        @(negedge mclk_in);
        req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk_in);
        q = {rvalid_in, rdata_in};
        req_out = '0;
    endtask
    // pair write, lower byte first
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr8(lo, v[7:0]);
        wr8(lo + 8'h01, v[15:8]);
    endtask
    // pair read, upper byte first; result is {upper, lower}
    task automatic rd16(input logic [7:0] lo, output logic [17:0] q);
        rd8(lo + 8'h01, q[17:9]);
        rd8(lo, q[8:0]);
    endtask
    // longest-frame pair write releases staged bounds; caller keeps it large
    task automatic apply(input logic [15:0] v);
        wr16(8'h19, v);
    endtask
endmodule

/* dv/tb_frame_shutter_bound_regs.sv */
// tb_frame_shutter_bound_regs.sv: self-checking bench of the bound register bank
// assumes: fsb_bound_regs with its package and map header, controller model
`timescale 1ns/1ps
`include "fsb_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_frame_shutter_bound_regs
    import fsb_pkg::*;
;
    // ----------------------------------------------------------------
    // signals and reference state
    // ----------------------------------------------------------------
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    fsb_req_s req; // strobes from the controller model
    logic fw_running = 1'b0;
    logic [7:0] fw_rev = 8'h00;
    logic automatic_gain_control = 1'b1;
    logic [15:0] sh_req = 16'h0000;
    logic [15:0] per_req = 16'h0000;
    logic [7:0] rdata;
    logic rvalid, busy, tick;
    logic [15:0] fper, shut;
    logic [17:0] q;
    logic [8:0] q9;
    int err_total = 0;
    int checked = 0;
    int st_min = 16'h0DAC, st_sh = 16'h208C; // readable staged bounds
    int ap_min = 16'h0DAC, ap_sh = 16'h208C; // bounds in effect
    int n, t1, ticks;
    // 25 MHz clock
    always #20 mclk_in = ~mclk_in;
    // ----------------------------------------------------------------
    // design and controller
    // ----------------------------------------------------------------
    fsb_bound_regs DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_req_in(req),
        .fw_running_in(fw_running), .fw_rev_in(fw_rev), .agc_enable_in(automatic_gain_control),
        .shutter_req_in(sh_req), .period_req_in(per_req), .rdata_out(rdata),
        .rvalid_out(rvalid), .busy_out(busy), .frame_tick_out(tick),
        .frame_period_out(fper), .shutter_out(shut));
    fsb_ctrl_model u_ctrl (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .busy_in(busy), .req_out(req));
    // ----------------------------------------------------------------
    // expectations and checks
    // ----------------------------------------------------------------
    // period floored by request, applied min and applied shutter ceiling
    function automatic logic [15:0] exp_per();
        int m;
        m = per_req;
        if (ap_min > m) m = ap_min;
        if (ap_sh > m) m = ap_sh;
        return m[15:0];
    endfunction
    // auto: request capped; manual: the ceiling itself
    function automatic logic [15:0] exp_sh();
        if (automatic_gain_control && sh_req < ap_sh) return sh_req;
        return ap_sh[15:0];
    endfunction
    // outputs once settled
    task automatic chk_out();
        repeat (3) @(negedge mclk_in);
        `CHK(fper, exp_per())
        `CHK(shut, exp_sh())
    endtask
    // both staged pairs read back
    task automatic chk_bounds();
        u_ctrl.rd16(`FSB_OFS_MIN_LO, q);
        `CHK(q, {1'b1, st_min[15:8], 1'b1, st_min[7:0]})
        u_ctrl.rd16(`FSB_OFS_SHUT_LO, q);
        `CHK(q, {1'b1, st_sh[15:8], 1'b1, st_sh[7:0]})
    endtask
    // revision byte
    task automatic chk_rev(input logic [7:0] e);
        u_ctrl.rd8(`FSB_OFS_FW_REV, q9);
        `CHK(q9, {1'b1, e})
    endtask
    // verdict and end of run
    task automatic give_verdict();
        $display("counts: checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    // main sequence
    initial begin
        fw_rev = 8'(($urandom(14634) % 255) + 1);
        per_req = 16'($urandom & 32'h0FFF);
        sh_req = 16'($urandom);
        repeat (6) @(negedge mclk_in);
        rstn_in = 1'b1;
        // values before download; revision hidden
        chk_bounds();
        chk_rev(8'h00);
        chk_out();
        $display("test reset defaults done");
        // download loads the other defaults; revision read-only; hole reads zero
        fw_running = 1'b1;
        st_min = 16'h0E7E;
        st_sh = 16'h2000;
        ap_min = st_min;
        ap_sh = st_sh;
        repeat (2) @(negedge mclk_in);
        chk_bounds();
        u_ctrl.wr8(`FSB_OFS_FW_REV, ~fw_rev);
        chk_rev(fw_rev);
        u_ctrl.wr8(8'h30, 8'h5A);
        u_ctrl.rd8(8'h30, q9);
        `CHK(q9, 9'h100)
        chk_out();
        $display("test download defaults done");
        // automatic and manual exposure with random requests
        for (int i = 0; i < 4; i++) begin
            automatic_gain_control = i[0];
            sh_req = 16'($urandom);
            per_req = 16'($urandom & 32'h3FFF);
            chk_out();
        end
        $display("test exposure modes done");
        // staged writes, then release and two-frame settling
        st_min = 16'h7E0E + ($urandom & 32'h3F);
        st_sh = $urandom & 32'h0FFF;
        u_ctrl.wr8(`FSB_OFS_MIN_LO, st_min[7:0]);
        u_ctrl.rd8(`FSB_OFS_MIN_LO, q9);
        `CHK(q9, {1'b1, st_min[7:0]})
        u_ctrl.wr8(`FSB_OFS_MIN_HI, st_min[15:8]);
        u_ctrl.wr16(`FSB_OFS_SHUT_LO, st_sh[15:0]);
        chk_bounds();
        chk_out();
        u_ctrl.apply(16'hFF00 | 16'($urandom));
        ap_min = st_min;
        ap_sh = st_sh;
        `CHK(busy, 1'b1)
        n = 0;
        ticks = 0;
        t1 = 0;
        // tick launched with the release edge counts as the first frame
        while (busy === 1'b1 && n < 100000) begin
            if (tick === 1'b1) begin
                ticks++;
                if (ticks == 1) t1 = n;
                if (ticks == 2) `CHK(n - t1, int'(fper))
            end
            @(negedge mclk_in);
            n++;
        end
        `CHK(ticks, 2)
        chk_out();
        $display("test staged apply done");
        give_verdict();
    end
    // hang guard: two frames of the largest staged bound plus margin
    initial begin
        #(90000 * 40);
        err_total++;
        give_verdict();
    end
endmodule
